/* hdl/ecs_decode.sv */
`timescale 1ns/1ps
module ecs_decode
    import ecs_pkg::*;
(
    input wire logic [15:0] addr,
    input wire logic [3:0] reg_base_nibble,
    input wire ecs_control_t ctrl,
    input wire ecs_base_t base,
    input wire ecs_size_t size,
    output ecs_sel_t hit
);

    // ****************************************
    // Window masks
    // ****************************************
    function automatic logic [5:0] gen_mask(input logic [2:0] code);
        gen_mask = ~(6'h3F >> code);
    endfunction : gen_mask

    wire logic [1:0] psize = {ctrl.prog_window_size_hi, ctrl.prog_window_size_lo};
    wire logic [2:0] pmask = (psize == 2'h0) ? 3'h0 : (psize == 2'h1) ? 3'h4 :
                             (psize == 2'h2) ? 3'h6 : 3'h7;
    wire logic prog_hit = ((addr[15:13] & pmask) == pmask);
    wire logic [5:0] gdiff = (addr[15:10] ^ base.general_base_bits) &
                             gen_mask(size.general_window_size);
    wire logic gen_hit = (size.general_window_size != GEN_SIZE_OFF) &&
                         (gdiff == 6'h00);
    wire logic blk_hit = (addr[15:12] == reg_base_nibble);
    wire logic io1_hit = blk_hit && !addr[11] && (addr[11:0] >= IO_ONE_FIRST);
    wire logic io2_hit = blk_hit && (addr[11:0] >= IO_TWO_FIRST);
    wire logic prog_on = ctrl.program_select_enable && prog_hit;

    // Overlap resolved here so stretch and pins agree on the winner
    assign hit.io_one = ctrl.io_one_enable && io1_hit;
    assign hit.io_two = ctrl.io_two_enable && io2_hit;
    assign hit.prog = prog_on && !(gen_hit && ctrl.general_priority);
    assign hit.gen = gen_hit && !(prog_on && !ctrl.general_priority);

endmodule : ecs_decode

/* hdl/ecs_pkg.sv */
// Behaviour
// - Program window size 00=64K, 01=32K, 10=16K, 11=8K, always ending at FFFFh.
// - General base bits compare against bus address bits 15 down to 10.
// - Only base bits above the general window size take part in matching.
// - General size 000=64K up to 110=1K, 111 disabled; resets to 111.
// - I/O one timing bit: 0 E-clock high only, 1 whole address-valid time.
// - I/O two timing bit: 0 E-clock high only, 1 whole address-valid time.
// - General polarity bit: 0 active low, 1 active high.
// - General timing bit: 0 E-clock high only, 1 whole address-valid time.
// - I/O one covers x060-x7FF, I/O two x800-xFFF in register block nibble.
// - Each I/O select follows its enable bit; both enables clear at reset.
// - Each I/O polarity bit: 1 active high, 0 active low.
// - Each select has its own two-bit stretch of zero to three bus clocks.
// - Program enable resets set in expanded mode, clear in single-chip mode.
// - Program stretch resets to one cycle in expanded mode, else none.
// - Priority 1 lets general select win overlaps; 0 lets program select win.
// - General select has no enable; size 0K disables it.
// - Program select is address-valid timed, active low, start set by size.
// - Stretch fields encode 00 none, 01 one, 10 two, 11 three cycles.
package ecs_pkg;

    // ****************************************
    // Register indices, byte address is four times these
    // ****************************************
    localparam logic [15:0] IDX_STRETCH = 16'h105C;
    localparam logic [15:0] IDX_CONTROL = 16'h105D;
    localparam logic [15:0] IDX_BASE = 16'h105E;
    localparam logic [15:0] IDX_SIZE = 16'h105F;

    // ****************************************
    // Field layouts
    // ****************************************
    typedef struct packed {
        logic [1:0] io_one_stretch;
        logic [1:0] io_two_stretch;
        logic [1:0] general_stretch;
        logic [1:0] program_stretch;
    } ecs_stretch_t;

    typedef struct packed {
        logic io_one_enable;
        logic io_one_polarity;
        logic io_two_enable;
        logic io_two_polarity;
        logic general_priority;
        logic program_select_enable;
        logic prog_window_size_hi;
        logic prog_window_size_lo;
    } ecs_control_t;

    typedef struct packed {
        logic [5:0] general_base_bits;
        logic [1:0] unused;
    } ecs_base_t;

    typedef struct packed {
        logic io_one_timing_sel;
        logic io_two_timing_sel;
        logic unused;
        logic general_polarity;
        logic general_timing_sel;
        logic [2:0] general_window_size;
    } ecs_size_t;

    typedef struct packed {
        logic io_one;
        logic io_two;
        logic prog;
        logic gen;
    } ecs_sel_t;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [7:0] RST_STRETCH = 8'h00;
    localparam logic [7:0] RST_STRETCH_EXP = 8'h01;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_CONTROL_EXP = 8'h04;
    localparam logic [7:0] RST_BASE = 8'h00;
    localparam logic [7:0] RST_SIZE = 8'h07;
    localparam logic [7:0] MASK_BASE = 8'hFC;
    localparam logic [7:0] MASK_SIZE = 8'hDF;
    localparam logic [2:0] GEN_SIZE_OFF = 3'h7;
    localparam logic [11:0] IO_ONE_FIRST = 12'h060;
    localparam logic [11:0] IO_TWO_FIRST = 12'h800;

endpackage : ecs_pkg

/* hdl/ecs_stretch.sv */
`timescale 1ns/1ps
module ecs_stretch
    import ecs_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic e_rise,
    input wire logic [1:0] cycles,
    output logic busy
);

    logic [1:0] count;
    wire logic [1:0] next_count = start ? cycles :
                                  (e_rise && count != 2'h0) ? count - 2'h1 : count;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            count <= 2'h0;
            busy <= 1'b0;
        end
        else
        begin
            count <= next_count;
            busy <= (next_count != 2'h0);
        end
    end

endmodule : ecs_stretch

/* hdl/ecs_top.sv */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module ecs_top
    import ecs_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic expanded_mode,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_access,
    input wire logic e_clk,
    input wire logic [3:0] reg_base_nibble,
    output logic io_select_one,
    output logic io_select_two,
    output logic program_select,
    output logic general_select,
    output logic stretch_active
);

    // ****************************************
    // Register file
    // ****************************************
    ecs_stretch_t stretch_register;
    ecs_control_t select_control_register;
    ecs_base_t general_select_base;
    ecs_size_t general_select_size_timing;

    wire logic [13:0] widx = avs_address[15:2];
    wire logic sel_str = (widx == IDX_STRETCH[13:0]);
    wire logic sel_ctl = (widx == IDX_CONTROL[13:0]);
    wire logic sel_bas = (widx == IDX_BASE[13:0]);
    wire logic sel_siz = (widx == IDX_SIZE[13:0]);
    wire logic req = avs_read || avs_write;
    wire logic wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire logic [7:0] wbyte = avs_writedata[7:0];
    wire logic [7:0] rbyte = sel_str ? stretch_register :
                             sel_ctl ? select_control_register :
                             sel_bas ? general_select_base :
                             sel_siz ? general_select_size_timing : 8'h00;

    // One wait state: answer on the cycle after the request is seen
    wire logic next_wait = !(req && avs_waitrequest);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest <= next_wait;
            avs_readdata <= {24'h00_0000, rbyte};
        end
    end

    // Mode strap caught at reset, synchronous so sampling a port is safe
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stretch_register <= expanded_mode ? RST_STRETCH_EXP : RST_STRETCH;
            select_control_register <= expanded_mode ? RST_CONTROL_EXP : RST_CONTROL;
            general_select_base <= RST_BASE;
            general_select_size_timing <= RST_SIZE;
        end
        else if (wr_go)
        begin
            if (sel_str)
                stretch_register <= wbyte;
            if (sel_ctl)
                select_control_register <= wbyte;
            if (sel_bas)
                general_select_base <= wbyte & MASK_BASE;
            if (sel_siz)
                general_select_size_timing <= wbyte & MASK_SIZE;
        end
    end

    // ****************************************
    // Decode and pin timing
    // ****************************************
    ecs_sel_t hit;

    ecs_decode u_decode (
        .addr(cpu_addr),
        .reg_base_nibble(reg_base_nibble),
        .ctrl(select_control_register),
        .base(general_select_base),
        .size(general_select_size_timing),
        .hit(hit)
    );

    wire logic e_high = cpu_access && e_clk;
    wire logic act_io1 = hit.io_one &&
        (general_select_size_timing.io_one_timing_sel ? cpu_access : e_high);
    wire logic act_io2 = hit.io_two &&
        (general_select_size_timing.io_two_timing_sel ? cpu_access : e_high);
    wire logic act_gen = hit.gen &&
        (general_select_size_timing.general_timing_sel ? cpu_access : e_high);
    wire logic act_prog = hit.prog && cpu_access;

    wire logic next_io1 = act_io1 ~^ select_control_register.io_one_polarity;
    wire logic next_io2 = act_io2 ~^ select_control_register.io_two_polarity;
    wire logic next_gen = act_gen ~^ general_select_size_timing.general_polarity;
    wire logic next_prog = !act_prog;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            io_select_one <= 1'b1;
            io_select_two <= 1'b1;
            program_select <= 1'b1;
            general_select <= 1'b1;
        end
        else
        begin
            io_select_one <= next_io1;
            io_select_two <= next_io2;
            program_select <= next_prog;
            general_select <= next_gen;
        end
    end

    // ****************************************
    // Stretch for the winning select
    // ****************************************
    logic access_d;
    logic e_clk_d;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            access_d <= 1'b0;
            e_clk_d <= 1'b0;
        end
        else
        begin
            access_d <= cpu_access;
            e_clk_d <= e_clk;
        end
    end

    wire logic access_start = cpu_access && !access_d;
    wire logic [1:0] str_cycles =
        hit.io_one ? stretch_register.io_one_stretch :
        hit.io_two ? stretch_register.io_two_stretch :
        hit.gen ? stretch_register.general_stretch :
        hit.prog ? stretch_register.program_stretch : 2'h0;

    ecs_stretch u_stretch (
        .clock(clock),
        .rst(rst),
        .start(access_start),
        .e_rise(e_clk && !e_clk_d),
        .cycles(str_cycles),
        .busy(stretch_active)
    );

endmodule : ecs_top

/* verif/ecs_ext_mem.sv */
`timescale 1ns/1ps
// ****
// Program memory, counts selected accesses
// ****
module ecs_ext_mem(
    input wire logic clock,
    input wire logic rst,
    input wire logic chip_sel_n,
    output int n_sel
);
    logic last_n = 1'h1;
    always @(posedge clock)
    begin
        last_n <= chip_sel_n;
        n_sel <= rst ? 0 : n_sel + (last_n && !chip_sel_n);
    end
endmodule : ecs_ext_mem

/* verif/ecs_monitor.sv */
`timescale 1ns/1ps
// ****
// Port checks
// ****
module ecs_monitor(
    input wire logic clock,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cpu_access,
    input wire logic io_select_one,
    input wire logic io_select_two,
    input wire logic program_select,
    input wire logic general_select,
    input wire logic stretch_active
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("bus not answered");
    property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one: assert property (p_one) else $error("answer too long");
    property p_rdhi; avs_readdata[31:8] == 24'h0; endproperty
    a_rdhi: assert property (p_rdhi) else $error("read data high bits set");
    property p_rst; disable iff (1'b0) rst |=> program_select && io_select_one &&
        io_select_two && general_select && !stretch_active && avs_waitrequest; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_pidle; !cpu_access |=> program_select; endproperty
    a_pidle: assert property (p_pidle) else $error("program select without access");
    property p_pcause; !program_select |-> $past(cpu_access); endproperty
    a_pcause: assert property (p_pcause) else $error("program select no cause");
    property p_idle; (!cpu_access && !avs_write) [*3] |-> $stable(io_select_one) &&
        $stable(io_select_two) && $stable(general_select); endproperty
    a_idle: assert property (p_idle) else $error("select moved while idle");
    property p_sstart; $rose(stretch_active) |-> $past(cpu_access); endproperty
    a_sstart: assert property (p_sstart) else $error("stretch without access");
    c_wr: cover property (avs_write && !avs_waitrequest);
    c_st: cover property ($rose(stretch_active));
    c_pr: cover property (!program_select);
endmodule : ecs_monitor
bind ecs_top ecs_monitor u_mon(.clock(clock), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_access(cpu_access), .io_select_one(io_select_one), .io_select_two(io_select_two),
    .program_select(program_select), .general_select(general_select),
    .stretch_active(stretch_active));

/* verif/tb_external_chip_select_decoder.sv */
`timescale 1ns/1ps
module tb_external_chip_select_decoder;
    import ecs_pkg::*;
    logic clock = 1'h0, rst = 1'h1, mode = 1'h1, rd = 1'h0, wr = 1'h0, acc = 1'h0, e = 1'h0;
    logic [15:0] adr = 16'h0, ca = 16'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic [3:0] be = 4'hF, nib = 4'h1, s;
    logic [7:0] q;
    logic wq, o1, o2, pr, ge, sa;
    int miscompares = 0, n_tests = 0, cycles = 0, len, n_prog, p0;
    ecs_top uut(.clock(clock), .rst(rst), .expanded_mode(mode), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(rdat), .avs_waitrequest(wq), .cpu_addr(ca), .cpu_access(acc),
        .e_clk(e), .reg_base_nibble(nib), .io_select_one(o1), .io_select_two(o2),
        .program_select(pr), .general_select(ge), .stretch_active(sa));
    ecs_ext_mem ext(.clock(clock), .rst(rst), .chip_sel_n(pr), .n_sel(n_prog));
    initial forever #5 clock = ~clock;
    task finish_test();
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end
    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    // One transfer, held until waitrequest is sampled low
    task bus(input logic w, input logic [15:0] i, input logic [7:0] d);
        adr <= {i[13:0], 2'h0};
        wd <= {24'h0, d};
        wr <= w;
        rd <= !w;
        @(posedge clock);
        while (wq !== 1'h0)
            @(posedge clock);
        q = rdat[7:0];
        wr <= 1'h0;
        rd <= 1'h0;
        @(posedge clock);
    endtask : bus
    task cs(input logic [15:0] a, input logic ec, input logic [3:0] exp);
        ca <= a;
        e <= ec;
        acc <= 1'h1;
        @(posedge clock);
        @(posedge clock);
        s = {o1, o2, pr, ge};
        acc <= 1'h0;
        repeat (2) @(posedge clock);
        chk("selects", {4'h0, s}, {4'h0, exp});
    endtask : cs
    task t_reset();
        for (int m = 1; m >= 0; m--)
        begin
            mode <= m[0];
            rst <= 1'h1;
            repeat (4) @(posedge clock);
            rst <= 1'h0;
            @(posedge clock);
            chk("idle", {4'h0, o1, o2, pr, ge}, 8'h0F);
            bus(1'h0, IDX_STRETCH, 8'h0);
            chk("stretch", q, m ? 8'h01 : 8'h00);
            bus(1'h0, IDX_CONTROL, 8'h0);
            chk("control", q, m ? 8'h04 : 8'h00);
            bus(1'h0, IDX_BASE, 8'h0);
            chk("base", q, 8'h00);
            bus(1'h0, IDX_SIZE, 8'h0);
            chk("size", q, 8'h07);
        end
        bus(1'h1, IDX_BASE, 8'hFF);
        bus(1'h1, IDX_SIZE, 8'hFF);
        be <= 4'h0;
        bus(1'h1, IDX_BASE, 8'h00);
        be <= 4'hF;
        bus(1'h1, 16'h105B, 8'hFF);
        bus(1'h0, IDX_BASE, 8'h0);
        chk("base", q, 8'hFC);
        bus(1'h0, IDX_SIZE, 8'h0);
        chk("size", q, 8'hDF);
        bus(1'h0, 16'h105B, 8'h0);
        chk("unmapped", q, 8'h00);
    endtask : t_reset
    task t_prog();
        logic [15:0] st;
        bus(1'h1, IDX_STRETCH, 8'h00);
        bus(1'h1, IDX_SIZE, 8'h07);
        p0 = n_prog;
        for (int p = 0; p < 4; p++)
        begin
            st = (p == 0) ? 16'h0000 : 16'hFFFF << (16 - p);
            bus(1'h1, IDX_CONTROL, 8'h04 | p[7:0]);
            cs(st, 1'h0, 4'hD);
            cs(st - 16'h1, 1'h0, p ? 4'hF : 4'hD);
        end
        chk("prog count", 8'(n_prog - p0), 8'h05);
        bus(1'h1, IDX_CONTROL, 8'h03);
        cs(16'hE000, 1'h0, 4'hF);
    endtask : t_prog
    task t_gen();
        logic [15:0] low;
        bus(1'h1, IDX_CONTROL, 8'h00);
        bus(1'h1, IDX_BASE, 8'h48);
        for (int c = 0; c < 7; c++)
        begin
            low = 16'((32'h1 << (16 - c)) - 32'h1);
            bus(1'h1, IDX_SIZE, 8'h18 | c[7:0]);
            cs(16'h4800 | low, 1'h0, 4'hF);
            cs(16'h4800 ^ (low + 16'h1), 1'h0, c ? 4'hE : 4'hF);
        end
        bus(1'h1, IDX_SIZE, 8'h1F);
        cs(16'h4800, 1'h1, 4'hE);
        bus(1'h1, IDX_SIZE, 8'h06);
        cs(16'h4800, 1'h0, 4'hF);
        cs(16'h4800, 1'h1, 4'hE);
        bus(1'h1, IDX_SIZE, 8'h18);
        bus(1'h1, IDX_CONTROL, 8'h04);
        cs(16'h4800, 1'h0, 4'hC);
        bus(1'h1, IDX_CONTROL, 8'h0C);
        cs(16'h4800, 1'h0, 4'hF);
    endtask : t_gen
    task t_io();
        bus(1'h1, IDX_CONTROL, 8'hA0);
        bus(1'h1, IDX_SIZE, 8'h87);
        cs(16'h105F, 1'h1, 4'hF);
        cs(16'h1060, 1'h1, 4'h7);
        cs(16'h17FF, 1'h0, 4'h7);
        cs(16'h1800, 1'h1, 4'hB);
        cs(16'h1FFF, 1'h0, 4'hF);
        cs(16'h1FFF, 1'h1, 4'hB);
        cs(16'h2060, 1'h1, 4'hF);
        bus(1'h1, IDX_SIZE, 8'h47);
        cs(16'h1060, 1'h0, 4'hF);
        cs(16'h1800, 1'h0, 4'hB);
        nib <= 4'h2;
        cs(16'h2060, 1'h1, 4'h7);
        cs(16'h1060, 1'h1, 4'hF);
        nib <= 4'h1;
        bus(1'h1, IDX_CONTROL, 8'hF0);
        cs(16'h1060, 1'h1, 4'hB);
        cs(16'h1800, 1'h1, 4'h7);
        bus(1'h1, IDX_CONTROL, 8'h50);
        cs(16'h1060, 1'h1, 4'h3);
        cs(16'h1800, 1'h1, 4'h3);
    endtask : t_io
    task t_stretch();
        bus(1'h1, IDX_SIZE, 8'hC0);
        for (int n = 0; n < 4; n++)
            for (int w = 0; w < 4; w++)
            begin
                bus(1'h1, IDX_CONTROL, (w == 3) ? 8'hAC : 8'hA4);
                bus(1'h1, IDX_STRETCH, {n[1:0], 2'h3 - n[1:0], 2'h3 - n[1:0], n[1:0]});
                ca <= (w == 0) ? 16'h1060 : (w == 1) ? 16'h1800 : 16'h2000;
                e <= 1'h0;
                acc <= 1'h1;
                len = 0;
                for (int k = 0; k < 24; k++)
                begin
                    @(posedge clock);
                    len += (sa === 1'h1);
                    e <= k[1];
                    if (k == 2)
                        acc <= 1'h0;
                end
                chk("stretch", 8'((len + 3) / 4), 8'(w[0] ? 3 - n : n));
            end
    endtask : t_stretch
    initial
    begin
        t_reset();
        t_prog();
        t_gen();
        t_io();
        t_stretch();
        finish_test();
    end
endmodule : tb_external_chip_select_decoder
